// *** design/dpw_io_map.vh ***
// Purpose: addresses, reset values and widths for the two-port io block
// Assumes: byte-wide data-memory port, one register per address
// Notes:   definitions only; included by bare name
`ifndef DPW_IO_MAP_VH
`define DPW_IO_MAP_VH

// ==========================================================
// data-memory addresses of the port registers
// ==========================================================
`define DPW_ADDR_PA_DATA     8'h14
`define DPW_ADDR_PA_DIR      8'h15
`define DPW_ADDR_PA_PULLUP   8'h16
`define DPW_ADDR_PA_WAKE     8'h17
`define DPW_ADDR_PB_DATA     8'h18
`define DPW_ADDR_PB_DIR      8'h19
`define DPW_ADDR_PB_PULLUP   8'h1a

// ==========================================================
// reset values
// ==========================================================
`define DPW_RST_PA_DATA      8'hff
`define DPW_RST_PA_DIR       8'hff
`define DPW_RST_PA_PULLUP    8'h00
`define DPW_RST_PA_WAKE      8'h00
`define DPW_RST_PB_DATA      5'h1f
`define DPW_RST_PB_DIR       5'h1f
`define DPW_RST_PB_PULLUP    5'h00

// ==========================================================
// line counts and data width
// ==========================================================
`define DPW_PA_LINES         8
`define DPW_PB_LINES         5
`define DPW_DATA_W           8
`define DPW_ADDR_W           8

`endif

// *** design/dpw_sync.v ***
// Purpose: two-flop synchroniser plus one history stage for edge compare
// Assumes: inputs are asynchronous pin levels
// Notes:   the first flop feeds only the second flop
`timescale 1ns/1ps

module dpw_sync
#(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
)
(
   input wire clk_sys,
   input wire srst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out,
   output wire [WIDTH-1:0] sync_prev
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] stable_ff;
   reg [WIDTH-1:0] prev_ff;

   // ==========================================================
   // synchroniser chain
   // ==========================================================
   // reset to idle-high so a released reset looks like a falling edge only on a line held low
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         meta_ff <= RST_VAL;
         stable_ff <= RST_VAL;
         prev_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= async_in;
         stable_ff <= meta_ff;
         prev_ff <= stable_ff;
      end
   end

   assign sync_out = stable_ff;
   assign sync_prev = prev_ff;

endmodule

// *** design/dpw_io_top.v ***
// Purpose: gpio for an 8-line port a and a 5-line port b with pull-ups
//          and falling-edge wake-up on port a
// Assumes: cpu data-memory strobes are on clk_sys; pins are asynchronous
// Notes:   all lines exist in logic whether bonded out or not
`timescale 1ns/1ps
`include "dpw_io_map.vh"

module dpw_io_top
#(
   parameter PA_W = `DPW_PA_LINES,
   parameter PB_W = `DPW_PB_LINES
)
(
   input wire clk_sys,
   input wire srst,
   // cpu data-memory side
   input wire [`DPW_ADDR_W-1:0] dm_addr,
   input wire dm_wr,
   input wire [`DPW_DATA_W-1:0] dm_wdata,
   input wire dm_rd,
   input wire second_clock_phase,
   output wire [`DPW_DATA_W-1:0] dm_rdata,
   output wire dm_hit,
   // core power state and pin-share selection
   input wire sleep_or_idle,
   input wire [PA_W-1:0] pa_alt_sel,
   input wire [PA_W-1:0] pa_alt_pu_ok,
   input wire [PB_W-1:0] pb_alt_sel,
   input wire [PB_W-1:0] pb_alt_pu_ok,
   // port a pins
   input wire [PA_W-1:0] pa_pin_in,
   output wire [PA_W-1:0] pa_pin_out,
   output wire [PA_W-1:0] pa_pin_oe_n,
   output wire [PA_W-1:0] pa_pullup_on,
   // port b pins
   input wire [PB_W-1:0] pb_pin_in,
   output wire [PB_W-1:0] pb_pin_out,
   output wire [PB_W-1:0] pb_pin_oe_n,
   output wire [PB_W-1:0] pb_pullup_on,
   // wake request to the power controller
   output wire wake_req
);

   // ==========================================================
   // helper functions
   // ==========================================================
   // read-back per line: input lines show the pin, outputs the latch
   function [`DPW_DATA_W-1:0] read_mux;
      input [`DPW_DATA_W-1:0] dir;
      input [`DPW_DATA_W-1:0] pin;
      input [`DPW_DATA_W-1:0] latch;
      begin
         read_mux = (dir & pin) | (~dir & latch);
      end
   endfunction

   // pull-up gate: gpio lines need input direction, shared lines need
   // a digital-input or open-drain function
   function [`DPW_DATA_W-1:0] pu_gate;
      input [`DPW_DATA_W-1:0] en;
      input [`DPW_DATA_W-1:0] dir;
      input [`DPW_DATA_W-1:0] alt;
      input [`DPW_DATA_W-1:0] alt_ok;
      begin
         pu_gate = en & ((~alt & dir) | (alt & alt_ok));
      end
   endfunction

   // ==========================================================
   // registers
   // ==========================================================
   // software-visible state, one register per address
   reg [PA_W-1:0] pa_data_ff;
   reg [PA_W-1:0] pa_dir_ff;
   reg [PA_W-1:0] pa_pullup_ff;
   reg [PA_W-1:0] pa_wake_ff;
   reg [PB_W-1:0] pb_data_ff;
   reg [PB_W-1:0] pb_dir_ff;
   reg [PB_W-1:0] pb_pullup_ff;
   // read return path and pad-control state
   reg [`DPW_DATA_W-1:0] rdata_ff;
   reg [`DPW_DATA_W-1:0] nxt_rdata;
   reg hit_ff;
   reg nxt_hit;
   reg wake_ff;
   reg [PA_W-1:0] pa_pu_on_ff;
   reg [PB_W-1:0] pb_pu_on_ff;

   // synchronised pin views and combinational helpers
   wire [PA_W-1:0] pa_sync;
   wire [PA_W-1:0] pa_prev;
   wire [PB_W-1:0] pb_sync;
   wire [`DPW_DATA_W-1:0] pa_rd_view;
   wire [`DPW_DATA_W-1:0] pb_rd_view;
   wire [`DPW_DATA_W-1:0] pa_pu_calc;
   wire [`DPW_DATA_W-1:0] pb_pu_calc;
   wire [PA_W-1:0] pa_fall;
   wire [PA_W-1:0] pa_wake_armed;
   wire rd_sample;
   wire [`DPW_DATA_W-PB_W-1:0] pb_pad;

   // zero fill that widens port b to the byte-wide bus; the missing upper
   // lines have no latch, so writes to them are simply dropped
   assign pb_pad = {(`DPW_DATA_W-PB_W){1'b0}};

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   // port a keeps a history stage for the falling-edge compare
   dpw_sync #(.WIDTH(PA_W), .RST_VAL({PA_W{1'b1}})) u_sync_pa
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in(pa_pin_in),
      .sync_out(pa_sync),
      .sync_prev(pa_prev)
   );

   // port b has no wake, so its history stage is left unused
   dpw_sync #(.WIDTH(PB_W), .RST_VAL({PB_W{1'b1}})) u_sync_pb
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in(pb_pin_in),
      .sync_out(pb_sync),
      .sync_prev()
   );

   // ==========================================================
   // cpu writes
   // ==========================================================
   // each register decodes its own address; all bits exist even for
   // lines with no pad so software can park them and avoid floating
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         pa_data_ff <= `DPW_RST_PA_DATA;
         pa_dir_ff <= `DPW_RST_PA_DIR;
         pa_pullup_ff <= `DPW_RST_PA_PULLUP;
         pa_wake_ff <= `DPW_RST_PA_WAKE;
         pb_data_ff <= `DPW_RST_PB_DATA;
         pb_dir_ff <= `DPW_RST_PB_DIR;
         pb_pullup_ff <= `DPW_RST_PB_PULLUP;
      end
      else if (dm_wr)
      begin
         case (dm_addr)
            `DPW_ADDR_PA_DATA:
               pa_data_ff <= dm_wdata[PA_W-1:0];
            `DPW_ADDR_PA_DIR:
               pa_dir_ff <= dm_wdata[PA_W-1:0];
            `DPW_ADDR_PA_PULLUP:
               pa_pullup_ff <= dm_wdata[PA_W-1:0];
            `DPW_ADDR_PA_WAKE:
               pa_wake_ff <= dm_wdata[PA_W-1:0];
            `DPW_ADDR_PB_DATA:
               pb_data_ff <= dm_wdata[PB_W-1:0];
            `DPW_ADDR_PB_DIR:
               pb_dir_ff <= dm_wdata[PB_W-1:0];
            `DPW_ADDR_PB_PULLUP:
               pb_pullup_ff <= dm_wdata[PB_W-1:0];
            default:
            begin
               pa_data_ff <= pa_data_ff;
            end
         endcase
      end
   end

   // ==========================================================
   // cpu reads
   // ==========================================================
   // the data registers carry no input latch: the pin view is taken
   // only at the second phase of the read, so a slow pin must be
   // settled by then
   assign rd_sample = dm_rd & second_clock_phase;
   assign pa_rd_view = read_mux(pa_dir_ff, pa_sync, pa_data_ff);
   assign pb_rd_view = read_mux({pb_pad, pb_dir_ff}, {pb_pad, pb_sync},
                                {pb_pad, pb_data_ff});

   // read decode; unused upper bits of port b read as zero
   always @*
   begin
      nxt_rdata = {`DPW_DATA_W{1'b0}};
      nxt_hit = 1'b1;
      case (dm_addr)
         `DPW_ADDR_PA_DATA:
            nxt_rdata = pa_rd_view;
         `DPW_ADDR_PA_DIR:
            nxt_rdata = pa_dir_ff;
         `DPW_ADDR_PA_PULLUP:
            nxt_rdata = pa_pullup_ff;
         `DPW_ADDR_PA_WAKE:
            nxt_rdata = pa_wake_ff;
         `DPW_ADDR_PB_DATA:
            nxt_rdata = pb_rd_view;
         `DPW_ADDR_PB_DIR:
            nxt_rdata = {pb_pad, pb_dir_ff};
         `DPW_ADDR_PB_PULLUP:
            nxt_rdata = {pb_pad, pb_pullup_ff};
         default:
            nxt_hit = 1'b0;
      endcase
   end

   // read data is held until the next sampled read
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         rdata_ff <= {`DPW_DATA_W{1'b0}};
         hit_ff <= 1'b0;
      end
      else if (rd_sample)
      begin
         rdata_ff <= nxt_rdata;
         hit_ff <= nxt_hit;
      end
   end

   // hit flag lets the core tell an unmapped read from a real zero
   assign dm_rdata = rdata_ff;
   assign dm_hit = hit_ff;

   // ==========================================================
   // pin drive
   // ==========================================================
   // output enable is the direction bit itself: 0 drives push-pull
   // lines given to a shared function still follow the latch here; the
   // shared function's own drive is muxed outside this block
   assign pa_pin_out = pa_data_ff;
   assign pa_pin_oe_n = pa_dir_ff;
   assign pb_pin_out = pb_data_ff;
   assign pb_pin_oe_n = pb_dir_ff;

   // ==========================================================
   // weak pull-ups
   // ==========================================================
   // an enabled pull-up on a driving gpio output would just waste current,
   // so the gate forces it off there; a shared line goes by alt_ok alone
   assign pa_pu_calc = pu_gate(pa_pullup_ff, pa_dir_ff, pa_alt_sel, pa_alt_pu_ok);
   assign pb_pu_calc = pu_gate({pb_pad, pb_pullup_ff}, {pb_pad, pb_dir_ff},
                               {pb_pad, pb_alt_sel}, {pb_pad, pb_alt_pu_ok});

   // registered so the pad control never glitches on mux decode
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         pa_pu_on_ff <= {PA_W{1'b0}};
         pb_pu_on_ff <= {PB_W{1'b0}};
      end
      else
      begin
         pa_pu_on_ff <= pa_pu_calc[PA_W-1:0];
         pb_pu_on_ff <= pb_pu_calc[PB_W-1:0];
      end
   end

   assign pa_pullup_on = pa_pu_on_ff;
   assign pb_pullup_on = pb_pu_on_ff;

   // ==========================================================
   // port a wake-up
   // ==========================================================
   // compare two synchronised samples; a line counts only as a gpio
   // input with its enable set, and only while the core is halted
   // edges that arrive while the core runs are not remembered: a switch
   // pressed just before the halt will not wake it
   assign pa_fall = pa_prev & ~pa_sync;
   assign pa_wake_armed = pa_wake_ff & pa_dir_ff & ~pa_alt_sel;

   // one pulse per clock with any enabled falling edge; edges that
   // land in the same cycle merge into a single request
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         wake_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= sleep_or_idle & (|(pa_fall & pa_wake_armed));
      end
   end

   assign wake_req = wake_ff;

endmodule

// *** verif/dpw_io_asserts.sv ***
// Purpose: port-level checks for the two-port io block
// Assumes: pins change only just after clk_sys edges
// Notes:   bound into dpw_io_top at the foot of this file
`timescale 1ns/1ps
`include "dpw_io_map.vh"

module dpw_io_asserts
#(
   parameter PA_W = 8,
   parameter PB_W = 5
)
(
   input wire clk_sys,
   input wire srst,
   input wire [`DPW_ADDR_W-1:0] dm_addr,
   input wire dm_wr,
   input wire [`DPW_DATA_W-1:0] dm_wdata,
   input wire dm_rd,
   input wire second_clock_phase,
   input wire [`DPW_DATA_W-1:0] dm_rdata,
   input wire dm_hit,
   input wire sleep_or_idle,
   input wire [PA_W-1:0] pa_alt_sel,
   input wire [PA_W-1:0] pa_alt_pu_ok,
   input wire [PB_W-1:0] pb_alt_sel,
   input wire [PB_W-1:0] pb_alt_pu_ok,
   input wire [PA_W-1:0] pa_pin_in,
   input wire [PA_W-1:0] pa_pin_out,
   input wire [PA_W-1:0] pa_pin_oe_n,
   input wire [PA_W-1:0] pa_pullup_on,
   input wire [PB_W-1:0] pb_pin_in,
   input wire [PB_W-1:0] pb_pin_out,
   input wire [PB_W-1:0] pb_pin_oe_n,
   input wire [PB_W-1:0] pb_pullup_on,
   input wire wake_req
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // only phase-qualified reads count
   wire rd_s = dm_rd & second_clock_phase;
   property p_pa_wr;
      dm_wr && dm_addr == `DPW_ADDR_PA_DATA |=> pa_pin_out == $past(dm_wdata);
   endproperty
   a_pa_wr: assert property (p_pa_wr) else $error("port a latch missed a write");
   property p_pa_hold;
      !(dm_wr && dm_addr == `DPW_ADDR_PA_DATA) |=> $stable(pa_pin_out);
   endproperty
   a_pa_hold: assert property (p_pa_hold) else $error("port a latch moved");
   property p_pb_dir;
      dm_wr && dm_addr == `DPW_ADDR_PB_DIR |=> pb_pin_oe_n == $past(dm_wdata[PB_W-1:0]);
   endproperty
   a_pb_dir: assert property (p_pb_dir) else $error("port b direction wrong");
   property p_hit;
      rd_s |=> dm_hit == ($past(dm_addr) >= 8'h14 && $past(dm_addr) <= 8'h1a);
   endproperty
   a_hit: assert property (p_hit) else $error("read hit flag wrong");
   property p_rd_latch;
      rd_s && dm_addr == `DPW_ADDR_PA_DATA |=>
         ((dm_rdata ^ $past(pa_pin_out)) & ~$past(pa_pin_oe_n)) == 8'h00;
   endproperty
   a_rd_latch: assert property (p_rd_latch) else $error("output line read wrong");
   property p_pb_mask;
      rd_s && dm_addr == `DPW_ADDR_PB_DATA |=> dm_rdata[7:5] == 3'h0;
   endproperty
   a_pb_mask: assert property (p_pb_mask) else $error("port b unused bits set");
   property p_pu_gate;
      (pa_pullup_on & $past((~pa_alt_sel & ~pa_pin_oe_n) | (pa_alt_sel & ~pa_alt_pu_ok))) == 0;
   endproperty
   a_pu_gate: assert property (p_pu_gate) else $error("pull-up on when gated");
   property p_wake_sleep;
      wake_req |-> $past(sleep_or_idle);
   endproperty
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake while running");
   property p_wake_fall;
      wake_req |-> (($past(pa_pin_in, 4) & ~$past(pa_pin_in, 3)) |
                    ($past(pa_pin_in, 5) & ~$past(pa_pin_in, 4))) != 0;
   endproperty
   a_wake_fall: assert property (p_wake_fall) else $error("wake without a fall");
   c_wake: cover property (wake_req);
   c_pu: cover property (pa_pullup_on != 0);
   c_miss: cover property (rd_s ##1 !dm_hit);
endmodule

bind dpw_io_top dpw_io_asserts #(.PA_W(PA_W), .PB_W(PB_W)) u_chk (.*);

// *** verif/dpw_pin_model.sv ***
// Purpose: external pins and loads on one port
// Assumes: the load drives only where ext_en is set
// Notes:   a line nobody holds wanders each cycle
`timescale 1ns/1ps

module dpw_pin_model
#(
   parameter W = 8
)
(
   input wire clk_sys,
   input wire [W-1:0] pin_out,
   input wire [W-1:0] oe_n,
   input wire [W-1:0] pullup_on,
   input wire [W-1:0] ext_en,
   input wire [W-1:0] ext_val,
   output logic [W-1:0] pin_lvl
);
   reg [W-1:0] float_ff = '0;
   // a floating line must never look like a stable level
   always @(posedge clk_sys) float_ff <= ~float_ff;
   // push-pull driver first, then the load, then the weak pull-up
   always @*
   begin
      pin_lvl = (~oe_n & pin_out) | (oe_n & ext_en & ext_val)
              | (oe_n & ~ext_en & (pullup_on | float_ff));
   end
endmodule

// *** verif/tb_top.sv ***
// Purpose: register and pin tests of the two-port io block
// Assumes: strobes change by non-blocking assignment at clk_sys edges
// Notes:   pins come from dpw_pin_model
`timescale 1ns/1ps
`include "dpw_io_map.vh"

module tb_top;
   reg clk_sys = 1'b0;
   reg srst = 1'b1;
   reg [7:0] dm_addr = 8'h00;
   reg dm_wr = 1'b0;
   reg [7:0] dm_wdata = 8'h00;
   reg dm_rd = 1'b0;
   reg second_clock_phase = 1'b0;
   reg sleep_or_idle = 1'b0;
   reg [7:0] pa_alt_sel = 8'h00;
   reg [7:0] pa_alt_pu_ok = 8'h00;
   reg [4:0] pb_alt_sel = 5'h00;
   reg [4:0] pb_alt_pu_ok = 5'h00;
   reg [7:0] ext_a = 8'h3c;
   reg [7:0] rv;
   reg seen;
   wire [7:0] dm_rdata, pa_pin_in, pa_pin_out, pa_pin_oe_n, pa_pullup_on;
   wire [4:0] pb_pin_in, pb_pin_out, pb_pin_oe_n, pb_pullup_on;
   wire dm_hit, wake_req;
   integer err_count = 0;
   integer checks = 0;
   integer cyc = 0;
   always #4 clk_sys = ~clk_sys;

   // ==========================================================
   // design and pins
   dpw_io_top DUT (.clk_sys(clk_sys), .srst(srst), .dm_addr(dm_addr), .dm_wr(dm_wr),
      .dm_wdata(dm_wdata), .dm_rd(dm_rd), .second_clock_phase(second_clock_phase),
      .dm_rdata(dm_rdata), .dm_hit(dm_hit), .sleep_or_idle(sleep_or_idle),
      .pa_alt_sel(pa_alt_sel), .pa_alt_pu_ok(pa_alt_pu_ok), .pb_alt_sel(pb_alt_sel),
      .pb_alt_pu_ok(pb_alt_pu_ok), .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out),
      .pa_pin_oe_n(pa_pin_oe_n), .pa_pullup_on(pa_pullup_on), .pb_pin_in(pb_pin_in),
      .pb_pin_out(pb_pin_out), .pb_pin_oe_n(pb_pin_oe_n), .pb_pullup_on(pb_pullup_on),
      .wake_req(wake_req));
   dpw_pin_model #(.W(8)) u_pa (.clk_sys(clk_sys), .pin_out(pa_pin_out), .oe_n(pa_pin_oe_n),
      .pullup_on(pa_pullup_on), .ext_en(8'hff), .ext_val(ext_a), .pin_lvl(pa_pin_in));
   dpw_pin_model #(.W(5)) u_pb (.clk_sys(clk_sys), .pin_out(pb_pin_out), .oe_n(pb_pin_oe_n),
      .pullup_on(pb_pullup_on), .ext_en(5'h1f), .ext_val(5'h0a), .pin_lvl(pb_pin_in));

   // ==========================================================
   // tasks
   task final_report;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input [7:0] got, input [7:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys);
      dm_addr <= a;
      dm_wdata <= d;
      dm_wr <= 1'b1;
      @(posedge clk_sys);
      dm_wr <= 1'b0;
   endtask
   // a read only counts when the phase marker is up
   task rd(input [7:0] a, input ph, output [7:0] d);
      @(posedge clk_sys);
      dm_addr <= a;
      dm_rd <= 1'b1;
      second_clock_phase <= ph;
      @(posedge clk_sys);
      dm_rd <= 1'b0;
      #1 d = dm_rdata;
   endtask
   task rchk(input [7:0] a, input [7:0] e);
      rd(a, 1'b1, rv);
      chk("dm_rdata", rv, e);
      chk("dm_hit", {7'h0, dm_hit}, {7'h0, a >= 8'h14 && a <= 8'h1a});
   endtask
   // the load sets the pins and the core state at one edge, then wake_req is watched
   task wake_try(input [7:0] lvl, input slp, input [7:0] alt, input exp);
      @(posedge clk_sys);
      ext_a <= lvl;
      sleep_or_idle <= slp;
      pa_alt_sel <= alt;
      seen = 1'b0;
      repeat (7) @(posedge clk_sys) #1 if (wake_req === 1'b1) seen = 1'b1;
      chk("wake_req", {7'h0, seen}, {7'h0, exp});
   endtask

   // a hang ends the run as a mismatch
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         err_count = err_count + 1;
         final_report;
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      #1 chk("pa_pin_out", pa_pin_out, 8'hff);
      chk("pa_pin_oe_n", pa_pin_oe_n, 8'hff);
      chk("pa_pullup_on", pa_pullup_on, 8'h00);
      rchk(`DPW_ADDR_PA_DIR, 8'hff);
      rchk(`DPW_ADDR_PA_PULLUP, 8'h00);
      rchk(`DPW_ADDR_PA_WAKE, 8'h00);
      rchk(`DPW_ADDR_PB_DIR, 8'h1f);
      rchk(`DPW_ADDR_PB_PULLUP, 8'h00);
      rchk(8'h1b, 8'h00);
      rd(`DPW_ADDR_PA_DIR, 1'b0, rv);
      chk("dm_rdata", rv, 8'h00);
      wr(`DPW_ADDR_PA_DIR, 8'h0f);
      wr(`DPW_ADDR_PA_DATA, 8'ha5);
      wr(8'h20, 8'h00);
      rchk(`DPW_ADDR_PA_DATA, 8'hac);
      chk("pa_pin_out", pa_pin_out, 8'ha5);
      wr(`DPW_ADDR_PB_DIR, 8'h00);
      wr(`DPW_ADDR_PB_DATA, 8'hff);
      pa_alt_sel <= 8'h30;
      pa_alt_pu_ok <= 8'h10;
      rchk(`DPW_ADDR_PB_DATA, 8'h1f);
      wr(`DPW_ADDR_PA_PULLUP, 8'hff);
      repeat (2) @(posedge clk_sys);
      #1 chk("pa_pullup_on", pa_pullup_on, 8'h1f);
      wr(`DPW_ADDR_PB_PULLUP, 8'hff);
      pb_alt_sel <= 5'h03;
      pb_alt_pu_ok <= 5'h01;
      repeat (2) @(posedge clk_sys);
      #1 chk("pb_pullup_on", {3'h0, pb_pullup_on}, 8'h01);
      chk("pb_pin_out", {3'h0, pb_pin_out}, 8'h1f);
      rchk(`DPW_ADDR_PB_PULLUP, 8'h1f);
      wake_try(8'hff, 1'b0, 8'h00, 1'b0);
      wr(`DPW_ADDR_PA_DIR, 8'hff);
      wr(`DPW_ADDR_PA_WAKE, 8'h81);
      wake_try(8'hfe, 1'b1, 8'h00, 1'b1);
      wake_try(8'hfd, 1'b1, 8'h00, 1'b0);
      wake_try(8'hff, 1'b1, 8'h00, 1'b0);
      wake_try(8'h7f, 1'b0, 8'h00, 1'b0);
      wake_try(8'hff, 1'b0, 8'h00, 1'b0);
      wake_try(8'h7f, 1'b1, 8'h80, 1'b0);
      wake_try(8'hff, 1'b1, 8'h80, 1'b0);
      wake_try(8'h7f, 1'b1, 8'h00, 1'b1);
      final_report;
   end
endmodule
